// File: logic/mgi_pkg.sv
// Shared constants for the message client link and its host end
package mgi_pkg;

    // Fixed seven-bit target address of the client
    localparam logic [6:0] MGI_DEV_ADDR = 7'h42;

    // System clock and link speed limit
    localparam int MGI_CLK_PERIOD_NS = 20;
    localparam int MGI_SCL_MAX_KHZ = 400;
    localparam int MGI_SCL_PERIOD_NS = 1_000_000 / MGI_SCL_MAX_KHZ;
    // Least half period of SCL, rounded up to whole cycles
    localparam logic [7:0] MGI_HALF_CYC = 8'((MGI_SCL_PERIOD_NS / 2
        + MGI_CLK_PERIOD_NS - 1) / MGI_CLK_PERIOD_NS);

    // Brief release of the status line between queued messages
    localparam int MGI_TS_GAP_NS = 2000;
    localparam logic [7:0] MGI_TS_GAP_CYC = 8'((MGI_TS_GAP_NS
        + MGI_CLK_PERIOD_NS - 1) / MGI_CLK_PERIOD_NS);

    // Queue limits
    localparam int MGI_MSG_DEPTH = 5;
    localparam int MGI_BYTE_DEPTH = 64;

    // Idle value of a byte shifted out with nothing queued
    localparam logic [7:0] MGI_FILL_BYTE = 8'hFF;
    // Bit slot of the acknowledge within a nine-bit frame
    localparam logic [3:0] MGI_ACK_SLOT = 4'h8;

endpackage

// File: logic/mgi_link_if.sv
// Open-drain two-wire link plus status line between host and client
`timescale 1ns/1ps
interface mgi_link_if;
    // Each party: output value and enable per line it drives; drive only pulls low
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic dev_ts_o;
    logic dev_ts_oe;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    // Resolved line levels, pull-ups make released lines high
    logic scl;
    logic sda;
    logic xfer_status_n;

    // Wired-AND of both parties on SCL and SDA; the status line is driven by the client only
    assign scl = !(dev_scl_oe && !dev_scl_o) && !(host_scl_oe && !host_scl_o);
    assign sda = !(dev_sda_oe && !dev_sda_o) && !(host_sda_oe && !host_sda_o);
    assign xfer_status_n = !(dev_ts_oe && !dev_ts_o);

    modport device (
        input scl, sda,
        output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
        output dev_ts_o, dev_ts_oe
    );
    modport host (
        input scl, sda, xfer_status_n,
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
    );
endinterface

// File: logic/mgi_pair_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module mgi_pair_buf #(
    parameter int W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } mgi_pb_st_t;

    mgi_pb_st_t r_q;
    mgi_pb_st_t r_d;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////
    // Honest full and empty from the occupancy count
    assign o_ready = (r_q.cnt != 2'd2);
    assign o_valid = (r_q.cnt != 2'd0);
    assign o_data = r_q.mem[r_q.rp];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    // Next state
    always_comb
    begin
        r_d = r_q;
        if (push)
        begin
            r_d.mem[r_q.wp] = i_data;
            r_d.wp = !r_q.wp;
        end
        if (pop)
            r_d.rp = !r_q.rp;
        r_d.cnt = 2'(r_q.cnt + {1'b0, push} - {1'b0, pop});
    end

    // State register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end
endmodule

// File: logic/mgi_client.sv
// Client end: address match, byte shifting, message queue, status line
`timescale 1ns/1ps
module mgi_client
    import mgi_pkg::*;
#(
    parameter int BYTE_DEPTH = MGI_BYTE_DEPTH,
    parameter int MSG_DEPTH = MGI_MSG_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    mgi_link_if.device bus,
    input wire logic [7:0] i_msg_data,
    input wire logic i_msg_last,
    input wire logic i_msg_valid,
    output logic o_msg_ready,
    output logic [7:0] o_cmd_data,
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    output logic [2:0] o_msg_count
);
    localparam int AW = $clog2(BYTE_DEPTH);

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_RACK, S_SKIP
    } mgi_st_t;

    typedef struct packed {
        logic [BYTE_DEPTH-1:0][8:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [2:0] msg_cnt;
        mgi_st_t st;
        logic [7:0] sh;
        logic [3:0] bits;
        logic rnw;
        logic ack;
        logic pushed;
        logic live;
        logic drop;
        logic hold;
        logic [7:0] gap;
        logic sda_oe;
        logic scl_q;
        logic sda_q;
    } mgi_cl_st_t;

    mgi_cl_st_t r_q;
    mgi_cl_st_t r_d;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic push;
    logic pop;
    logic msg_inc;
    logic msg_dec;
    logic [8:0] head;
    logic [7:0] next_byte;
    logic cmd_valid;
    logic cmd_ready;

    ////////////////////////////////////////////////////////////////////
    // Received command bytes pass a two-entry buffer; a stalled user
    // makes the client stretch SCL instead of losing a byte
    mgi_pair_buf #(
        .W(8)
    ) u_cmd_buf (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_valid(cmd_valid),
        .o_ready(cmd_ready),
        .i_data(r_q.sh),
        .o_valid(o_cmd_valid),
        .i_ready(i_cmd_ready),
        .o_data(o_cmd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Line conditions, seen against the previous sample
    assign rise = !r_q.scl_q && bus.scl;
    assign fall = r_q.scl_q && !bus.scl;
    assign start = r_q.scl_q && bus.scl && r_q.sda_q && !bus.sda;
    assign stop = r_q.scl_q && bus.scl && !r_q.sda_q && bus.sda;

    // Queue accepts bytes while a byte slot is free and fewer than MSG_DEPTH messages are complete
    assign o_msg_ready = (r_q.cnt != (AW+1)'(BYTE_DEPTH))
        && (r_q.msg_cnt < 3'(MSG_DEPTH));
    assign push = i_msg_valid && o_msg_ready;
    assign head = r_q.mem[r_q.rp];
    assign o_msg_count = r_q.msg_cnt;

    // Pins: open drain, only ever pull low
    assign bus.dev_scl_o = 1'b0;
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_ts_o = 1'b0;
    assign bus.dev_sda_oe = r_q.sda_oe;
    // Hold SCL low until the buffer takes the byte
    assign bus.dev_scl_oe = (r_q.st == S_WACK) && !r_q.pushed;
    // Released during a read and a short gap after it
    assign bus.dev_ts_oe = (r_q.msg_cnt != 3'd0) && !r_q.hold
        && (r_q.gap == 8'd0);
    assign cmd_valid = (r_q.st == S_WACK) && !r_q.pushed;

    // Byte for the next read slot: queue head while the message lasts
    always_comb
    begin
        next_byte = MGI_FILL_BYTE;
        if (r_q.live && r_q.cnt != '0)
            next_byte = head[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Protocol engine and queue bookkeeping
    always_comb
    begin
        r_d = r_q;
        pop = 1'b0;
        msg_inc = push && i_msg_last;
        msg_dec = 1'b0;
        r_d.scl_q = bus.scl;
        r_d.sda_q = bus.sda;
        if (r_q.gap != 8'd0)
            r_d.gap = 8'(r_q.gap - 8'd1);
        unique case (r_q.st)
            S_IDLE, S_SKIP:
            begin
                // Wait for a start; mismatched transfers end here
            end
            S_ADDR:
            begin
                if (rise)
                begin
                    r_d.sh = {r_q.sh[6:0], bus.sda};
                    r_d.bits = 4'(r_q.bits + 4'd1);
                end
                else if (fall && r_q.bits == 4'd8)
                begin
                    if (r_q.sh[7:1] == MGI_DEV_ADDR)
                    begin
                        r_d.st = S_AACK;
                        r_d.sda_oe = 1'b1;
                        r_d.rnw = r_q.sh[0];
                        if (r_q.sh[0] && r_q.msg_cnt != 3'd0)
                        begin
                            // Message leaves the queue as the read starts
                            msg_dec = 1'b1;
                            r_d.live = 1'b1;
                            r_d.hold = 1'b1;
                        end
                    end
                    else
                        r_d.st = S_SKIP;
                end
            end
            S_AACK:
            begin
                if (fall)
                begin
                    r_d.bits = 4'd0;
                    if (r_q.rnw)
                    begin
                        r_d.st = S_RD;
                        r_d.sh = next_byte;
                        r_d.sda_oe = !next_byte[7];
                        pop = r_q.live && r_q.cnt != '0;
                    end
                    else
                    begin
                        r_d.st = S_WR;
                        r_d.sda_oe = 1'b0;
                    end
                end
            end
            S_WR:
            begin
                if (rise)
                begin
                    r_d.sh = {r_q.sh[6:0], bus.sda};
                    r_d.bits = 4'(r_q.bits + 4'd1);
                end
                else if (fall && r_q.bits == 4'd8)
                begin
                    r_d.st = S_WACK;
                    r_d.sda_oe = 1'b1;
                    r_d.pushed = 1'b0;
                end
            end
            S_WACK:
            begin
                if (cmd_ready)
                    r_d.pushed = 1'b1;
                if (fall)
                begin
                    r_d.st = S_WR;
                    r_d.sda_oe = 1'b0;
                    r_d.bits = 4'd0;
                end
            end
            S_RD:
            begin
                if (rise)
                    r_d.bits = 4'(r_q.bits + 4'd1);
                else if (fall && r_q.bits == 4'd8)
                begin
                    // Release SDA for the host's acknowledge
                    r_d.st = S_RACK;
                    r_d.sda_oe = 1'b0;
                end
                else if (fall)
                begin
                    r_d.sh = {r_q.sh[6:0], 1'b0};
                    r_d.sda_oe = !r_q.sh[6];
                end
            end
            S_RACK:
            begin
                if (rise)
                    r_d.ack = !bus.sda;
                else if (fall && r_q.ack)
                begin
                    r_d.st = S_RD;
                    r_d.bits = 4'd0;
                    r_d.sh = next_byte;
                    r_d.sda_oe = !next_byte[7];
                    pop = r_q.live && r_q.cnt != '0;
                end
                else if (fall)
                    r_d.st = S_SKIP;
            end
        endcase
        // Head byte that closes the message ends the live read
        if (pop && head[8])
            r_d.live = 1'b0;
        // Leftover bytes of an ended read are thrown away
        if (r_q.drop && !pop && r_q.cnt != '0)
        begin
            pop = 1'b1;
            if (head[8])
                r_d.drop = 1'b0;
        end
        else if (r_q.drop && r_q.cnt == '0)
            r_d.drop = 1'b0;
        // Start or stop ends any transfer in progress
        if (start || stop)
        begin
            r_d.st = start ? S_ADDR : S_IDLE;
            r_d.bits = 4'd0;
            r_d.sda_oe = 1'b0;
            if (r_q.live && !(pop && head[8]))
            begin
                r_d.live = 1'b0;
                r_d.drop = 1'b1;
            end
            if (r_q.hold)
            begin
                r_d.hold = 1'b0;
                r_d.gap = MGI_TS_GAP_CYC;
            end
        end
        // Queue storage and counts
        if (push)
        begin
            r_d.mem[r_q.wp] = {i_msg_last, i_msg_data};
            r_d.wp = (r_q.wp == AW'(BYTE_DEPTH - 1)) ? '0
                : AW'(r_q.wp + 1'b1);
        end
        if (pop)
            r_d.rp = (r_q.rp == AW'(BYTE_DEPTH - 1)) ? '0
                : AW'(r_q.rp + 1'b1);
        r_d.cnt = (AW+1)'(r_q.cnt + {{AW{1'b0}}, push}
            - {{AW{1'b0}}, pop});
        r_d.msg_cnt = 3'(r_q.msg_cnt + {2'b00, msg_inc}
            - {2'b00, msg_dec});
    end

    ////////////////////////////////////////////////////////////////////
    // State register; line samples start at idle high
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            r_q <= '0;
            r_q.scl_q <= 1'b1;
            r_q.sda_q <= 1'b1;
        end
        else
            r_q <= r_d;
    end
endmodule

// File: logic/mgi_host.sv
// Host end: drives SCL, frames transfers, waits on the status line before reads
`timescale 1ns/1ps
module mgi_host
    import mgi_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    mgi_link_if.host bus,
    input wire logic i_go,
    input wire logic i_read,
    input wire logic [7:0] i_len,
    input wire logic [7:0] i_wr_data,
    output logic o_wr_take,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_busy,
    output logic o_nack
);
    typedef enum logic [2:0] {
        H_IDLE, H_WAIT_TS, H_START, H_BIT, H_STOP
    } mgi_hst_t;

    typedef struct packed {
        mgi_hst_t st;
        logic [7:0] tmr;
        logic hi;
        logic [8:0] tx;
        logic [7:0] rx;
        logic [3:0] bits;
        logic [7:0] idx;
        logic [7:0] len;
        logic rd;
        logic scl_oe;
        logic sda_oe;
        logic nack;
        logic [7:0] rd_data;
        logic rd_valid;
        logic wr_take;
    } mgi_h_st_t;

    mgi_h_st_t r_q;
    mgi_h_st_t r_d;
    logic [8:0] frame;
    logic last;

    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe = r_q.scl_oe;
    assign bus.host_sda_oe = r_q.sda_oe;
    assign o_wr_take = r_q.wr_take;
    assign o_rd_data = r_q.rd_data;
    assign o_rd_valid = r_q.rd_valid;
    assign o_busy = (r_q.st != H_IDLE);
    assign o_nack = r_q.nack;

    ////////////////////////////////////////////////////////////////////
    // Next data frame; reads release SDA and NACK only the final byte
    assign last = (8'(r_q.idx + 8'd1) == r_q.len);
    assign frame = r_q.rd ? {MGI_FILL_BYTE, last} : {i_wr_data, 1'b1};

    ////////////////////////////////////////////////////////////////////
    // Bit engine: low half, release, wait for SCL high, high half
    always_comb
    begin
        r_d = r_q;
        r_d.rd_valid = 1'b0;
        r_d.wr_take = 1'b0;
        if (r_q.tmr != 8'd0)
            r_d.tmr = 8'(r_q.tmr - 8'd1);
        unique case (r_q.st)
            H_IDLE:
            begin
                if (i_go)
                begin
                    r_d.rd = i_read;
                    r_d.len = i_len;
                    r_d.idx = 8'd0;
                    r_d.nack = 1'b0;
                    r_d.st = i_read ? H_WAIT_TS : H_START;
                    r_d.sda_oe = !i_read;
                    r_d.tmr = MGI_HALF_CYC;
                end
            end
            H_WAIT_TS:
            begin
                // Read only once the client signals a pending message
                if (!bus.xfer_status_n)
                begin
                    r_d.st = H_START;
                    r_d.sda_oe = 1'b1;
                    r_d.tmr = MGI_HALF_CYC;
                end
            end
            H_START:
            begin
                if (r_q.tmr == 8'd0)
                begin
                    r_d.st = H_BIT;
                    r_d.scl_oe = 1'b1;
                    r_d.tx = {MGI_DEV_ADDR, r_q.rd, 1'b1};
                    r_d.sda_oe = !MGI_DEV_ADDR[6];
                    r_d.bits = 4'd0;
                    r_d.hi = 1'b0;
                    r_d.tmr = MGI_HALF_CYC;
                end
            end
            H_BIT:
            begin
                if (!r_q.hi && r_q.tmr == 8'd0)
                begin
                    r_d.scl_oe = 1'b0;
                    r_d.hi = 1'b1;
                    r_d.tmr = MGI_HALF_CYC;
                end
                else if (r_q.hi && !bus.scl)
                    r_d.tmr = MGI_HALF_CYC;
                else if (r_q.hi && r_q.tmr == 8'd0)
                begin
                    r_d.scl_oe = 1'b1;
                    r_d.hi = 1'b0;
                    r_d.tmr = MGI_HALF_CYC;
                    if (r_q.bits != MGI_ACK_SLOT)
                    begin
                        r_d.rx = {r_q.rx[6:0], bus.sda};
                        r_d.bits = 4'(r_q.bits + 4'd1);
                        r_d.tx = {r_q.tx[7:0], 1'b1};
                        r_d.sda_oe = !r_q.tx[7];
                    end
                    else
                    begin
                        if (r_q.rd && r_q.idx != 8'd0)
                        begin
                            r_d.rd_data = r_q.rx;
                            r_d.rd_valid = 1'b1;
                        end
                        if (!r_q.rd || r_q.idx == 8'd0)
                            r_d.nack = bus.sda;
                        if (r_q.idx == r_q.len
                            || ((!r_q.rd || r_q.idx == 8'd0) && bus.sda))
                        begin
                            r_d.st = H_STOP;
                            r_d.sda_oe = 1'b1;
                        end
                        else
                        begin
                            r_d.tx = frame;
                            r_d.sda_oe = !frame[8];
                            r_d.wr_take = !r_q.rd;
                            r_d.idx = 8'(r_q.idx + 8'd1);
                            r_d.bits = 4'd0;
                        end
                    end
                end
            end
            H_STOP:
            begin
                if (!r_q.hi && r_q.tmr == 8'd0)
                begin
                    r_d.scl_oe = 1'b0;
                    r_d.hi = 1'b1;
                    r_d.tmr = MGI_HALF_CYC;
                end
                else if (r_q.hi && !bus.scl)
                    r_d.tmr = MGI_HALF_CYC;
                else if (r_q.hi && r_q.tmr == 8'd0)
                begin
                    r_d.sda_oe = 1'b0;
                    r_d.st = H_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end
endmodule

// File: tb/mgi_link_props.sv
// Protocol checker for the two-wire link between host and client ends
`timescale 1ns/1ps
module mgi_link_props
    import mgi_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic xfer_status_n
);
    // Half period is 63 clocks; small margin for edge detection lag
    localparam int HMIN = 60;
    logic scl_q;
    logic [7:0] run_q;
    logic [3:0] bit_q;
    logic [7:0] sr_q;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Level run length of SCL; bits of the first frame after a start
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            scl_q <= 1'b1;
            run_q <= 8'h00;
            bit_q <= 4'hF;
            sr_q <= 8'h00;
        end
        else
        begin
            scl_q <= scl;
            run_q <= (scl != scl_q) ? 8'h00 : run_q + 8'(run_q != 8'hFF);
            if (scl && scl_q && $fell(sda))
                bit_q <= 4'h0;
            else if (scl && !scl_q && bit_q < 4'h9)
            begin
                bit_q <= bit_q + 4'h1;
                sr_q <= {sr_q[6:0], sda};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_addr;
        (bit_q == 4'h6) ##1 (bit_q == 4'h7) |-> sr_q[6:0] == MGI_DEV_ADDR;
    endproperty
    property p_ack;
        (bit_q == 4'h8) ##1 (bit_q == 4'h9) |-> !sr_q[0];
    endproperty
    property p_hold_high;
        $fell(scl) |-> run_q >= 8'(HMIN);
    endproperty
    property p_hold_low;
        $rose(scl) |-> run_q >= 8'(HMIN);
    endproperty
    property p_sda_steady;
        scl && $past(scl) |-> $stable(dev_sda_oe);
    endproperty
    property p_ack_setup;
        $rose(dev_sda_oe) |-> !scl;
    endproperty
    property p_stretch;
        $rose(dev_scl_oe) |-> !scl;
    endproperty
    property p_ts_gap;
        $rose(xfer_status_n) |-> xfer_status_n [*8];
    endproperty
    property p_start;
        scl && $past(scl) && $fell(sda) |-> ##[1:70] !scl;
    endproperty

    a_addr: assert property (p_addr)
        else $error("address frame differs from client address");
    a_ack: assert property (p_ack)
        else $error("address frame not acknowledged");
    a_hold_high: assert property (p_hold_high)
        else $error("SCL high phase too short");
    a_hold_low: assert property (p_hold_low)
        else $error("SCL low phase too short");
    a_sda_steady: assert property (p_sda_steady)
        else $error("client changed SDA while SCL high");
    a_ack_setup: assert property (p_ack_setup)
        else $error("client pulled SDA while SCL high");
    a_stretch: assert property (p_stretch)
        else $error("client grabbed SCL while high");
    a_ts_gap: assert property (p_ts_gap)
        else $error("status release too brief");
    a_start: assert property (p_start)
        else $error("no SCL fall after start");

    // Main scenarios reached
    c_start: cover property (scl && $past(scl) && $fell(sda));
    c_stretch: cover property ($rose(dev_scl_oe));
    c_ts_gap: cover property ($rose(xfer_status_n));
endmodule

// File: tb/i2c_client_msg_fifo_status_tb_top.sv
// Testbench joining client and host ends of the message link
`timescale 1ns/1ps
module i2c_client_msg_fifo_status_tb_top;
    import mgi_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_msg_data = 8'h00;
    logic i_msg_last = 1'b0;
    logic i_msg_valid = 1'b0;
    logic i_cmd_ready = 1'b1;
    logic i_go = 1'b0;
    logic i_read = 1'b0;
    logic [7:0] i_len = 8'h00;
    logic o_msg_ready, o_cmd_valid, o_wr_take, o_rd_valid, o_busy, o_nack;
    logic [7:0] o_cmd_data, o_rd_data;
    logic [2:0] o_msg_count;
    logic [7:0] wr_bytes [4] = '{8'hA5, 8'h3C, 8'h80, 8'h01};
    logic [1:0] wr_idx = 2'h0;
    logic [7:0] rd_q [$];
    logic [7:0] cmd_q [$];
    int mismatches = 0;
    int checks_done = 0;

    ////////////////////////////////////////////////////////////////////////
    mgi_link_if u_mgi_link_if ();
    mgi_client u_mgi_client (.i_clk_sys, .i_reset_n,
        .bus(u_mgi_link_if.device), .i_msg_data, .i_msg_last, .i_msg_valid,
        .o_msg_ready, .o_cmd_data, .o_cmd_valid, .i_cmd_ready, .o_msg_count);
    mgi_host u_mgi_host (.i_clk_sys, .i_reset_n, .bus(u_mgi_link_if.host),
        .i_go, .i_read, .i_len, .i_wr_data(wr_bytes[wr_idx]), .o_wr_take,
        .o_rd_data, .o_rd_valid, .o_busy, .o_nack);
    mgi_link_props u_mgi_link_props (.i_clk_sys, .i_reset_n,
        .dev_scl_oe(u_mgi_link_if.dev_scl_oe),
        .dev_sda_oe(u_mgi_link_if.dev_sda_oe),
        .scl(u_mgi_link_if.scl), .sda(u_mgi_link_if.sda),
        .xfer_status_n(u_mgi_link_if.xfer_status_n));

    // 50 MHz system clock
    always #10 i_clk_sys = ~i_clk_sys;

    // Collect read bytes and delivered commands; next write byte on take
    always @(posedge i_clk_sys)
    begin
        if (o_rd_valid === 1'b1)
            rd_q.push_back(o_rd_data);
        if (o_cmd_valid === 1'b1 && i_cmd_ready)
            cmd_q.push_back(o_cmd_data);
    end
    always @(negedge i_clk_sys)
        if (o_wr_take === 1'b1)
            wr_idx <= wr_idx + 2'h1;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // One message of n bytes counting up from base; waits while refused
    task automatic push_msg(input logic [7:0] base, input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            @(negedge i_clk_sys);
            i_msg_data = base + 8'(i);
            i_msg_last = (i == n - 1);
            i_msg_valid = 1'b1;
            k = 0;
            while (o_msg_ready !== 1'b1 && k < 100)
            begin
                @(negedge i_clk_sys);
                k++;
            end
        end
        @(negedge i_clk_sys);
        i_msg_valid = 1'b0;
    endtask

    // One host transfer; bounded wait for the host to go idle
    task automatic xfer(input logic rd, input logic [7:0] len);
        int k;
        rd_q.delete();
        @(negedge i_clk_sys);
        i_read = rd;
        i_len = len;
        i_go = 1'b1;
        @(negedge i_clk_sys);
        i_go = 1'b0;
        k = 0;
        while (o_busy !== 1'b0 && k < 20000)
        begin
            @(negedge i_clk_sys);
            k++;
        end
        check(8'(o_busy), 8'h00);
    endtask

    task automatic read_chk(input logic [7:0] len, input logic [7:0] base);
        xfer(1'b1, len);
        check(8'(rd_q.size()), len);
        foreach (rd_q[i]) check(rd_q[i], base + 8'(i));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        wait_n(6);
        i_reset_n = 1'b1;
        wait_n(2);
        check(8'(u_mgi_link_if.xfer_status_n), 8'h01);
        // Receiver stalls, so the client must stretch and lose nothing
        i_cmd_ready = 1'b0;
        fork
            xfer(1'b0, 8'h04);
            begin
                wait_n(6000);
                i_cmd_ready = 1'b1;
            end
        join
        wait_n(4);
        check(8'(cmd_q.size()), 8'h04);
        foreach (cmd_q[i]) check(cmd_q[i], wr_bytes[i]);
        check(8'(o_nack), 8'h00);
        for (int m = 0; m < 5; m++)
            push_msg(8'(m * 16), 2);
        wait_n(2);
        check(8'(o_msg_count), 8'h05);
        check(8'(o_msg_ready), 8'h00);
        check(8'(u_mgi_link_if.xfer_status_n), 8'h00);
        read_chk(8'h02, 8'h00);
        check(8'(o_msg_count), 8'h04);
        check(8'(u_mgi_link_if.xfer_status_n), 8'h01);
        wait_n(150);
        check(8'(u_mgi_link_if.xfer_status_n), 8'h00);
        // Abort after one byte: the rest of that message is gone
        read_chk(8'h01, 8'h10);
        check(8'(o_msg_count), 8'h03);
        for (int m = 2; m < 5; m++)
            read_chk(8'h02, 8'(m * 16));
        wait_n(150);
        check(8'(o_msg_count), 8'h00);
        check(8'(u_mgi_link_if.xfer_status_n), 8'h01);
        // Read requested with nothing queued waits for the status line
        fork
            read_chk(8'h01, 8'h70);
            begin
                wait_n(500);
                check(8'({u_mgi_link_if.scl, u_mgi_link_if.sda}), 8'h3);
                push_msg(8'h70, 1);
            end
        join
        wrap_up();
    end

    // Watchdog well beyond the expected run of about 28000 cycles
    initial
    begin
        repeat (80000) @(posedge i_clk_sys);
        mismatches++;
        wrap_up();
    end
endmodule
